/* File: rtl/buck_protection_gain_sequencer.sv */
`default_nettype none
module buck_protection_gain_sequencer #(
   parameter int unsigned DETECT_CNT = bpg_pkg::DETECT_CYCLES,
   parameter int unsigned IDLE_CNT   = bpg_pkg::IDLE_CYCLES
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic [bpg_pkg::TEMP_W-1:0]    junctionTemp,
   input  wire logic [1:0]                    resMeasure,
   input  wire logic                          valleyCurrentLimit,
   input  wire logic                          pwmRequest,
   input  wire logic                          softStartDone,
   input  wire logic                          compFaultSeen,
   output logic                               highSideGateDrive,
   output logic                               lowSideGateDrive,
   output logic                               gainRefEnable,
   output logic [1:0]                         gainCode,
   output logic                               softStartRun,
   output logic                               controllerEnable,
   output logic                               thermalShutdown,
   output logic                               hiccupIdle
);
   import bpg_pkg::*;

   // resistor to gain mapping
   function automatic logic [1:0] resToGain(input logic [1:0] r);
      unique case (bpg_res_t'(r))
         RES_47K:  resToGain = GAIN_3X;
         RES_22K:  resToGain = GAIN_6X;
         RES_OPEN: resToGain = GAIN_12X;
         RES_100K: resToGain = GAIN_24X;
      endcase
   endfunction

   // synchronised pin inputs
   logic [TEMP_W-1:0] tempS1_q, tempS2_q;
   logic [1:0]        resS1_q, resS2_q;
   logic [4:0]        pinS1_q, pinS2_q;
   logic              limS, pwmS, ssDoneS, compS, limPrev_q;

   // two-stage sync of the multi-bit level inputs
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tempS1_q <= '0;
         tempS2_q <= '0;
         resS1_q  <= 2'h0;
         resS2_q  <= 2'h0;
      end else begin
         tempS1_q <= junctionTemp;
         tempS2_q <= tempS1_q;
         resS1_q  <= resMeasure;
         resS2_q  <= resS1_q;
      end
   end

   // two-stage sync of the single-bit control pins, idle low after reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinS1_q  <= 5'h00;
         pinS2_q  <= 5'h00;
      end else begin
         pinS1_q  <= {valleyCurrentLimit, pwmRequest, softStartDone, compFaultSeen, 1'b0};
         pinS2_q  <= pinS1_q;
      end
   end

   // synchronised pin taps
   assign limS    = pinS2_q[4];
   assign pwmS    = pinS2_q[3];
   assign ssDoneS = pinS2_q[2];
   assign compS   = pinS2_q[1];

   // thermal hysteresis
   logic thermal_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         thermal_q <= 1'b0;
      end else if (tempS2_q > TEMP_W'(TEMP_ENTER_C)) begin
         thermal_q <= 1'b1;
      end else if (tempS2_q < TEMP_W'(TEMP_EXIT_C)) begin
         thermal_q <= 1'b0;
      end
   end

   // sequencer state
   bpg_state_t state_q, state_d;
   logic [31:0] timer_q;
   logic [5:0]  viol_q;
   logic        retryFail_q;
   logic        limEdge;
   logic        violFull;

   assign limEdge  = limS & ~limPrev_q;
   assign violFull = (viol_q == 6'(VIOL_LIMIT));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_DETECT: begin
            if (timer_q >= DETECT_CNT - 1) begin
               state_d = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (violFull) begin
               state_d = ST_IDLE;
            end else if (ssDoneS) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (violFull) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (timer_q >= IDLE_CNT - 1) begin
               state_d = retryFail_q ? ST_DOWN : ST_RETRY;
            end
         end
         ST_RETRY: begin
            if (compS || violFull) begin
               state_d = ST_IDLE;
            end else if (ssDoneS) begin
               state_d = ST_RUN;
            end
         end
         ST_DOWN: begin
            state_d = ST_DETECT;
         end
         ST_THERMAL: begin
            if (!thermal_q) begin
               state_d = ST_DETECT;
            end
         end
         default: state_d = ST_DETECT;
      endcase
      if (thermal_q) begin
         state_d = ST_THERMAL;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_DETECT;
      end else begin
         state_q <= state_d;
      end
   end

   // phase timer, restarts on every state change
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_q <= 32'h0;
      end else if (state_d != state_q) begin
         timer_q <= 32'h0;
      end else begin
         timer_q <= timer_q + 32'h1;
      end
   end

   // failed retry remembered so next idle ends in power-down
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         retryFail_q <= 1'b0;
      end else if (state_q == ST_RETRY && state_d == ST_IDLE) begin
         retryFail_q <= 1'b1;
      end else if (state_q == ST_DOWN || state_d == ST_RUN) begin
         retryFail_q <= 1'b0;
      end
   end

   // violation counter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         viol_q    <= 6'h00;
      end else begin
         if ((state_d == ST_SOFT || state_d == ST_RETRY) && state_d != state_q) begin
            viol_q <= 6'h00;
         end else if (limEdge && !violFull &&
                      (state_q == ST_SOFT || state_q == ST_RUN || state_q == ST_RETRY)) begin
            viol_q <= viol_q + 6'h01;
         end
      end
   end

   // previous limit level for edge detection, idle low like the pin
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         limPrev_q <= 1'b0;
      end else begin
         limPrev_q <= limS;
      end
   end

   // gain latched at end of detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gainCode <= GAIN_RESET;
      end else if (state_q == ST_DETECT && state_d == ST_SOFT) begin
         gainCode <= resToGain(resS2_q);
      end
   end

   // gate drive with dead time interlock
   logic       switching;
   logic [1:0] dead_q;
   logic       hsOn_q, lsOn_q;
   assign switching = (state_q == ST_SOFT) || (state_q == ST_RUN) || (state_q == ST_RETRY);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hsOn_q <= 1'b0;
         lsOn_q <= 1'b0;
         dead_q <= 2'h0;
      end else if (!switching || thermal_q) begin
         hsOn_q <= 1'b0;
         lsOn_q <= 1'b0;
         dead_q <= 2'h0;
      end else if (pwmS != hsOn_q && (hsOn_q || lsOn_q)) begin
         hsOn_q <= 1'b0;
         lsOn_q <= 1'b0;
         dead_q <= 2'(DEAD_CYCLES);
      end else if (dead_q != 2'h0) begin
         dead_q <= dead_q - 2'h1;
      end else begin
         hsOn_q <= pwmS;
         lsOn_q <= ~pwmS;
      end
   end

   // next state still switching: gates drop on the same edge the flags rise
   logic switchNext;
   assign switchNext = (state_d == ST_SOFT) || (state_d == ST_RUN) || (state_d == ST_RETRY);

   // gate outputs, cut by the next state so idle and shutdown never show a pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         highSideGateDrive <= 1'b0;
         lowSideGateDrive  <= 1'b0;
      end else begin
         highSideGateDrive <= hsOn_q & ~lsOn_q & switchNext;
         lowSideGateDrive  <= lsOn_q & ~hsOn_q & switchNext;
      end
   end

   // reference level on the low-side pin while detecting
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gainRefEnable <= 1'b0;
      end else begin
         gainRefEnable <= (state_d == ST_DETECT);
      end
   end

   // soft start ramp request, normal start and retry
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         softStartRun <= 1'b0;
      end else begin
         softStartRun <= (state_d == ST_SOFT) || (state_d == ST_RETRY);
      end
   end

   // controller enable, low in shutdown and in the power-down cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         controllerEnable <= 1'b0;
      end else begin
         controllerEnable <= (state_d != ST_THERMAL) && (state_d != ST_DOWN);
      end
   end

   // thermal shutdown flag, same edge as the gates drop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         thermalShutdown <= 1'b0;
      end else begin
         thermalShutdown <= thermal_q;
      end
   end

   // hiccup idle flag
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hiccupIdle <= 1'b0;
      end else begin
         hiccupIdle <= (state_d == ST_IDLE);
      end
   end
endmodule
`default_nettype wire

/* File: rtl/bpg_pkg.sv */
`default_nettype none
package bpg_pkg;
   // clock
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 25;
   // gain-detect phase length
   localparam int unsigned DETECT_TIME_US  = 800;
   localparam int unsigned DETECT_CYCLES   = DETECT_TIME_US * (CLK_HZ / 1_000_000);
   // hiccup idle length
   localparam int unsigned IDLE_TIME_MS    = 6;
   localparam int unsigned IDLE_CYCLES     = IDLE_TIME_MS * (CLK_HZ / 1_000);
   // fault handling
   localparam int unsigned VIOL_LIMIT      = 32;
   localparam int unsigned DEAD_CYCLES     = 2;
   // thermal thresholds, degrees C
   localparam int unsigned TEMP_ENTER_C    = 155;
   localparam int unsigned TEMP_EXIT_C     = 140;
   localparam int unsigned TEMP_W          = 8;
   // gain codes
   localparam logic [1:0] GAIN_3X          = 2'h0;
   localparam logic [1:0] GAIN_6X          = 2'h1;
   localparam logic [1:0] GAIN_12X         = 2'h2;
   localparam logic [1:0] GAIN_24X         = 2'h3;
   localparam logic [1:0] GAIN_RESET       = GAIN_12X;

   // resistor measured by the detect converter
   typedef enum logic [1:0] {
      RES_47K  = 2'b00,
      RES_22K  = 2'b01,
      RES_OPEN = 2'b10,
      RES_100K = 2'b11
   } bpg_res_t;

   typedef enum logic [2:0] {
      ST_DETECT  = 3'b000,
      ST_SOFT    = 3'b001,
      ST_RUN     = 3'b010,
      ST_IDLE    = 3'b011,
      ST_RETRY   = 3'b100,
      ST_DOWN    = 3'b101,
      ST_THERMAL = 3'b110
   } bpg_state_t;
endpackage
`default_nettype wire

/* File: tb/bpg_asserts.sv */
`default_nettype none
module bpg_asserts
   import bpg_pkg::*;
#(parameter int unsigned IDLE_CNT = IDLE_CYCLES) (
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic [TEMP_W-1:0] junctionTemp,
   input wire logic              highSideGateDrive,
   input wire logic              lowSideGateDrive,
   input wire logic              gainRefEnable,
   input wire logic              softStartRun,
   input wire logic              controllerEnable,
   input wire logic              thermalShutdown,
   input wire logic              hiccupIdle
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [31:0] idleCnt_q;
   // cycles spent in hiccup idle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) idleCnt_q <= '0;
      else idleCnt_q <= hiccupIdle ? idleCnt_q + 32'h1 : '0;
   end
   sequence hotSeq;
      (junctionTemp > TEMP_ENTER_C)[*5];
   endsequence
   sequence warmSeq;
      (thermalShutdown && junctionTemp >= TEMP_EXIT_C)[*5];
   endsequence
   sequence idleEnd;
      $fell(hiccupIdle) && !thermalShutdown;
   endsequence
   chk_no_overlap: assert property (!(highSideGateDrive && lowSideGateDrive))
      else $error("both gates on");
   chk_thermal_entry: assert property (hotSeq |=> thermalShutdown)
      else $error("no thermal shutdown");
   chk_thermal_off: assert property (thermalShutdown |-> !controllerEnable
      && !highSideGateDrive && !lowSideGateDrive) else $error("drives on when hot");
   chk_thermal_hold: assert property (warmSeq |=> thermalShutdown)
      else $error("left shutdown too early");
   chk_idle_off: assert property (hiccupIdle |-> !highSideGateDrive && !lowSideGateDrive)
      else $error("drives on in idle");
   chk_detect_first: assert property (gainRefEnable |-> !softStartRun && !highSideGateDrive)
      else $error("ramp during detect");
   chk_idle_length: assert property (idleEnd |-> idleCnt_q >= IDLE_CNT - 1
      && idleCnt_q <= IDLE_CNT + 1) else $error("idle length wrong");
   chk_idle_restart: assert property (idleEnd |-> ##[0:2] (softStartRun || !controllerEnable))
      else $error("no restart after idle");
endmodule
bind buck_protection_gain_sequencer bpg_asserts #(.IDLE_CNT(IDLE_CNT)) u_chk (.sys_clk,
   .rst, .junctionTemp, .highSideGateDrive, .lowSideGateDrive, .gainRefEnable,
   .softStartRun, .controllerEnable, .thermalShutdown, .hiccupIdle);
`default_nettype wire

/* File: tb/bpg_stage.sv */
`default_nettype none
module bpg_stage (
   input  wire logic       lowSideGateDrive,
   input  wire logic       shorted,
   input  wire logic [1:0] resSel,
   output logic            valleyCurrentLimit,
   output logic [1:0]      resMeasure
);
   timeunit 1ns;
   timeprecision 1ps;
   // shorted output: every low-side conduction overshoots the limit
   assign valleyCurrentLimit = shorted && lowSideGateDrive;
   // converter reading of the fitted resistor
   assign resMeasure = resSel;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bpg_pkg::*;
   localparam int unsigned DET = 20;
   localparam int unsigned IDL = 50;
   logic sys_clk = 1'b0, rst = 1'b1, pwmRequest = 1'b1, softStartDone = 1'b0;
   logic compFaultSeen = 1'b0, shorted = 1'b0, valleyCurrentLimit, highSideGateDrive;
   logic lowSideGateDrive, gainRefEnable, softStartRun, controllerEnable;
   logic thermalShutdown, hiccupIdle;
   logic [TEMP_W-1:0] junctionTemp = 8'h19;
   logic [1:0] resSel = 2'h0, resMeasure, gainCode;
   int num_errors = 0, num_checks = 0, cyc = 0, i, n;
   // resistor rows beside the gain each should latch
   logic [1:0] rowRes [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [1:0] rowGain [4] = '{GAIN_3X, GAIN_6X, GAIN_12X, GAIN_24X};
   always #12.5 sys_clk = ~sys_clk;
   buck_protection_gain_sequencer #(.DETECT_CNT(DET), .IDLE_CNT(IDL)) DUT (.sys_clk, .rst,
      .junctionTemp, .resMeasure, .valleyCurrentLimit, .pwmRequest, .softStartDone,
      .compFaultSeen, .highSideGateDrive, .lowSideGateDrive, .gainRefEnable, .gainCode,
      .softStartRun, .controllerEnable, .thermalShutdown, .hiccupIdle);
   bpg_stage partner (.lowSideGateDrive, .shorted, .resSel, .valleyCurrentLimit, .resMeasure);
   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
      #2;
   endtask
   function automatic logic outSel(input int s);
      case (s)
         0: return softStartRun;
         1: return hiccupIdle;
         2: return gainRefEnable;
         default: return controllerEnable;
      endcase
   endfunction
   // bounded wait for an output to reach a level
   task automatic await(input int s, input logic lvl, input int lim);
      for (n = 0; n < lim && outSel(s) !== lvl; n++) tick(1);
   endtask
   // one low-side conduction period per pass
   task automatic pulses(input int c);
      repeat (c) begin
         pwmRequest = 1'b0;
         tick(10);
         pwmRequest = 1'b1;
         tick(10);
      end
   endtask
   // full startup from reset with a chosen resistor
   task automatic boot(input logic [1:0] r);
      rst = 1'b1;
      resSel = r;
      tick(10);
      check("reset gain", gainCode, GAIN_RESET);
      rst = 1'b0;
      tick(1);
      check("detect on", gainRefEnable, 1);
      for (n = 0; n < DET + 9 && gainRefEnable; n++) tick(1);
      check("detect length", n >= DET - 2 && n <= DET + 1, 1);
      check("soft after detect", softStartRun, 1);
   endtask
   // timeout guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results;
      end
   end
   initial begin
      for (i = 0; i < 4; i++) begin
         boot(rowRes[i]);
         check("gain code", gainCode, rowGain[i]);
      end
      // hiccup: 31 violations pass, the 32nd idles
      softStartDone = 1'b1;
      tick(5);
      shorted = 1'b1;
      pulses(31);
      check("idle at 31", hiccupIdle, 0);
      pulses(1);
      check("idle at 32", hiccupIdle, 1);
      softStartDone = 1'b0;
      await(1, 1'b0, IDL + 5);
      tick(1);
      check("retry ramp", softStartRun, 1);
      compFaultSeen = 1'b1;
      await(1, 1'b1, 10);
      check("idle again", hiccupIdle, 1);
      await(3, 1'b0, IDL + 10);
      check("power down", controllerEnable, 0);
      await(2, 1'b1, 5);
      check("restart detect", gainRefEnable, 1);
      compFaultSeen = 1'b0;
      await(2, 1'b0, DET + 5);
      pulses(32);
      check("count cleared", hiccupIdle, 1);
      shorted = 1'b0;
      await(1, 1'b0, IDL + 5);
      softStartDone = 1'b1;
      tick(6);
      check("resume run", {softStartRun, hiccupIdle, controllerEnable}, 1);
      pwmRequest = 1'b0;
      tick(10);
      check("low side", {highSideGateDrive, lowSideGateDrive}, 1);
      pwmRequest = 1'b1;
      tick(10);
      check("high side", {highSideGateDrive, lowSideGateDrive}, 2);
      // thermal thresholds at their boundaries
      junctionTemp = 8'h9b;
      tick(8);
      check("at 155", thermalShutdown, 0);
      junctionTemp = 8'h9c;
      tick(5);
      check("above 155", {thermalShutdown, controllerEnable, lowSideGateDrive}, 4);
      junctionTemp = 8'h8c;
      tick(8);
      check("at 140", thermalShutdown, 1);
      junctionTemp = 8'h8b;
      await(2, 1'b1, 8);
      check("resume", thermalShutdown, 0);
      results;
   end
endmodule
`default_nettype wire
